/* bench/sss_chk_sva.sv */
// Assertion checker for the software style register block
`timescale 1ns/1ns
module sss_chk (
  // Clock, reset, enable
  input wire        MCLK,
  input wire        ARST_N,
  input wire        CE,
  // Register port
  input wire [7:0]  ADDR,
  input wire        RD,
  input wire [31:0] RDATA,
  // Run state and error inputs
  input wire        STOP,
  input wire        SUSPEND_REQ,
  input wire [31:0] DMA_ADDR,
  input wire        DMA_DATA_PERR,
  input wire        TGT_DATA_PERR,
  input wire        ADDR_PERR,
  // Watched outputs
  input wire [31:0] MASTER_ADDR,
  input wire [7:0]  MASTER_ADDR_HI_OE,
  input wire        BPE_MARK,
  input wire [31:0] BPE_MASK,
  input wire        PERR_REPORT,
  input wire        WIDE_STRUCT,
  input wire        BURST_DESC,
  input wire        STYLE_RESERVED,
  input wire [7:0]  STRUCT_STYLE
);
  // Edges since release; sync reset ends after two
  reg [1:0] up_r;
  wire      rdy = (up_r == 2'h3) && CE;
  // Count up to the first legal request edge
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  a_hi_oe_on: assert property (MASTER_ADDR_HI_OE == 8'hFF)
    else $error("upper address enables dropped");
  a_mask_bit23: assert property (BPE_MASK == {8'h00, BPE_MARK, 23'h0})
    else $error("parity mask not on bit 23");
  a_perr_report: assert property (rdy && (DMA_DATA_PERR || TGT_DATA_PERR || ADDR_PERR)
    |=> PERR_REPORT)
    else $error("parity error not reported");
  a_bpe_dma_only: assert property (rdy && !DMA_DATA_PERR |=> !BPE_MARK)
    else $error("buffer mark without master data error");
  a_wide_decode: assert property (WIDE_STRUCT == (STRUCT_STYLE != 8'h00))
    else $error("wide flag not derived from style");
  a_style_codes: assert property (BURST_DESC == (STRUCT_STYLE == 8'h03) &&
    STYLE_RESERVED == (STRUCT_STYLE != 8'h00 && STRUCT_STYLE != 8'h02 &&
    STRUCT_STYLE != 8'h03))
    else $error("style decode wrong");
  a_gate_style: assert property (rdy && !STOP && !SUSPEND_REQ
    |=> $stable(STRUCT_STYLE))
    else $error("style changed while running");
  a_addr_low: assert property (rdy |=> MASTER_ADDR[23:0] == $past(DMA_ADDR[23:0]))
    else $error("low master address wrong");
  a_wide_addr: assert property (rdy && WIDE_STRUCT |=> MASTER_ADDR == $past(DMA_ADDR))
    else $error("wide master address wrong");
  a_style_read: assert property (rdy && RD && (ADDR == 8'h00 || ADDR == 8'h04)
    |=> RDATA[31:11] == 21'h0 && !RDATA[9] &&
    RDATA[8:0] == {$past(WIDE_STRUCT), $past(STRUCT_STYLE)})
    else $error("style read image wrong");
  a_rdata_idle: assert property (rdy && !RD |=> RDATA == 32'h0)
    else $error("read data outside read cycle");
  // Main scenarios
  cover property (rdy && RD);
  cover property (BPE_MARK);
  cover property (WIDE_STRUCT && BURST_DESC);
  cover property (STYLE_RESERVED);
endmodule
bind sss_top sss_chk sss_chk_i (.*);

/* bench/sss_top_tb_top.sv */
// Self-checking testbench for the software style register block
`timescale 1ns/1ns
module sss_top_tb_top;
  // Driven inputs
  reg        mclk, arst_n, ce, wr, rd, stop, susp;
  reg        dperr, tperr, aperr;
  reg [7:0]  addr, c;
  reg [31:0] wdata, dma_addr;
  // Observed outputs
  wire [31:0] rdata, maddr, bmask;
  wire [7:0]  hi_oe, style;
  wire        bmark, perr, wide, burst, resv, word_io;
  integer     errors, checked, i;
  sss_top sss_top_i (
    .MCLK(mclk), .ARST_N(arst_n), .CE(ce), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .STOP(stop), .SUSPEND_REQ(susp),
    .DMA_ADDR(dma_addr), .DMA_DATA_PERR(dperr), .TGT_DATA_PERR(tperr),
    .ADDR_PERR(aperr), .MASTER_ADDR(maddr), .MASTER_ADDR_HI_OE(hi_oe),
    .BPE_MARK(bmark), .BPE_MASK(bmask), .PERR_REPORT(perr),
    .WIDE_STRUCT(wide), .BURST_DESC(burst), .STYLE_RESERVED(resv),
    .STRUCT_STYLE(style), .WORD_IO(word_io));
  // 125 MHz clock
  always #4 mclk = ~mclk;
  // Verdict and end of run
  task finish_test;
    begin
      if (errors == 0 && checked > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  // Compare one value
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One-cycle register write
  task reg_wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
      #1;
    end
  endtask
  // One-cycle read, data judged in the next cycle
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      #1;
      chk(rdata, exp);
    end
  endtask
  // Set stop and suspend levels
  task run_state(input s, input p);
    begin
      @(posedge mclk);
      stop <= s;
      susp <= p;
    end
  endtask
  // Pulse master, target, address errors
  task pulse(input [2:0] e);
    begin
      @(posedge mclk);
      {dperr, tperr, aperr} <= e;
      @(posedge mclk);
      {dperr, tperr, aperr} <= 3'h0;
      #1;
    end
  endtask
  // Present a master address, judge it a cycle later
  task addr_chk(input [31:0] d, input [31:0] exp);
    begin
      @(posedge mclk);
      dma_addr <= d;
      @(posedge mclk);
      #1;
      chk(maddr, exp);
    end
  endtask
  // Reset values
  task t_reset;
    begin
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h0);
      chk(hi_oe, 32'hFF);
    end
  endtask
  // Gated writes, alias, read-only flag
  task t_gate;
    begin
      reg_wr(8'h00, 32'h403);
      rd_chk(8'h00, 32'h0);
      run_state(1'b1, 1'b0);
      reg_wr(8'h00, 32'h403);
      rd_chk(8'h04, 32'h503);
      run_state(1'b0, 1'b0);
      rd_chk(8'h00, 32'h503);
      run_state(1'b0, 1'b1);
      reg_wr(8'h04, 32'h100);
      rd_chk(8'h00, 32'h0);
    end
  endtask
  // Style codes 00h to 03h and FFh, defined and reserved
  task t_styles;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        c = (i == 4) ? 8'hFF : i;
        reg_wr(8'h00, {24'h0, c});
        chk(wide, c != 8'h00);
        chk(style, c);
        chk(burst, c == 8'h03);
        chk(resv, c != 8'h00 && c != 8'h02 && c != 8'h03);
        rd_chk(8'h04, {23'h0, c != 8'h00, c});
      end
    end
  endtask
  // Clock enable low freezes the style field
  task t_freeze;
    begin
      @(posedge mclk);
      ce <= 1'b0;
      reg_wr(8'h00, 32'h2);
      @(posedge mclk);
      ce <= 1'b1;
      rd_chk(8'h00, 32'h1FF);
    end
  endtask
  // Parity marking with enable on and off
  task t_parity;
    begin
      reg_wr(8'h00, 32'h402);
      pulse(3'h4);
      chk(bmask, 32'h00800000);
      chk(perr, 1'b1);
      pulse(3'h2);
      chk({bmark, perr}, 2'h1);
      pulse(3'h1);
      chk({bmark, perr}, 2'h1);
      reg_wr(8'h00, 32'h002);
      pulse(3'h4);
      chk({bmark, perr}, 2'h1);
    end
  endtask
  // Address high byte, I/O width, unmapped place
  task t_addr;
    begin
      reg_wr(8'h08, 32'hAB000000);
      reg_wr(8'h0C, 32'h80);
      reg_wr(8'h00, 32'h0);
      addr_chk(32'h12345678, 32'hAB345678);
      chk(word_io, 1'b1);
      reg_wr(8'h00, 32'h2);
      addr_chk(32'h12345678, 32'h12345678);
      chk(word_io, 1'b1);
      rd_chk(8'h08, 32'hAB000000);
      reg_wr(8'h20, 32'hFFFFFFFF);
      rd_chk(8'h20, 32'h0);
    end
  endtask
  // Hardware reset in mid-run clears the fields
  task t_hreset;
    begin
      reg_wr(8'h00, 32'h403);
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      rd_chk(8'h00, 32'h0);
    end
  endtask
  // Main sequence
  initial begin
    {mclk, arst_n, wr, rd, stop, susp, dperr, tperr, aperr} = 9'h0;
    ce       = 1'b1;
    addr     = 8'h00;
    wdata    = 32'h0;
    dma_addr = 32'h0;
    errors   = 0;
    checked  = 0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset;
    t_gate;
    t_styles;
    t_freeze;
    t_parity;
    t_addr;
    t_hreset;
    finish_test;
  end
  // Hang guard
  initial begin
    #100000;
    errors = errors + 1;
    finish_test;
  end
endmodule

/* inc/sss_consts.vh */
// Constants for the software style configuration register block
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH

// Register byte offsets
`define SSS_OFS_STYLE      8'h00
`define SSS_OFS_MIRROR     8'h04
`define SSS_OFS_INIT_HI    8'h08
`define SSS_OFS_BUS_MODE   8'h0C
`define SSS_OFS_STATUS     8'h10

// Field positions in the style register
`define SSS_STYLE_LSB      0
`define SSS_STYLE_MSB      7
`define SSS_WIDE_BIT       8
`define SSS_APAR_BIT       10

// Field position of the high init address byte
`define SSS_INIT_HI_LSB    24
`define SSS_INIT_HI_MSB    31

// Word I/O select position in the bus mode register
`define SSS_WORD_IO_BIT    7

// Buffer parity error flag position in descriptor word 1
`define SSS_BPE_BIT        23

// Style encodings
`define SSS_STYLE_NARROW   8'h00
`define SSS_STYLE_RES1     8'h01
`define SSS_STYLE_WIDE     8'h02
`define SSS_STYLE_BURST    8'h03

// Reset values
`define SSS_RST_STYLE      8'h00
`define SSS_RST_APAR       1'b0
`define SSS_RST_INIT_HI    8'h00
`define SSS_RST_WORD_IO    1'b0

`endif

/* verilog/sss_rst_sync.v */
// Two-stage release synchroniser for the asynchronous reset
`timescale 1ns/1ns
module sss_rst_sync (
  // Clock and raw reset
  input  wire clk,
  input  wire arst_n,
  // Synchronised reset
  output wire rst_n
);

  // Release shift chain
  reg stage1_r;    // First stage, read only by second
  reg stage2_r;    // Second stage, used as reset

  // Assert at once, release after two edges
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
    end else begin
      stage1_r <= 1'b1;
      stage2_r <= stage1_r;
    end
  end

  assign rst_n = stage2_r;

endmodule

/* verilog/sss_style_dec.v */
// Decoder from style code to structure width and burst attributes
`timescale 1ns/1ns
`include "sss_consts.vh"
module sss_style_dec (
  // Style code in
  input  wire [7:0] style,
  // Decoded attributes
  output wire       wide,
  output wire       burst,
  output wire       reserved
);

  // Wide structures for every code but the narrow one
  function dec_wide;
    input [7:0] s;
    begin
      dec_wide = (s != `SSS_STYLE_NARROW);
    end
  endfunction

  // Only the known codes are legal
  function dec_res;
    input [7:0] s;
    begin
      dec_res = (s != `SSS_STYLE_NARROW) && (s != `SSS_STYLE_WIDE) &&
                (s != `SSS_STYLE_BURST);
    end
  endfunction

  assign wide     = dec_wide(style);
  assign burst    = (style == `SSS_STYLE_BURST);
  assign reserved = dec_res(style);

endmodule

/* verilog/sss_top.v */
// Software style configuration register with alias, parity marking and address high byte
`timescale 1ns/1ns
`include "sss_consts.vh"
// Behaviour
// - Both register names share one storage
// - Reserved bits written zero, read zero here
// - Enabled parity marks buffer error bit 23
// - Enable leaves address and target errors alone
// - Parity enable gated writes, hardware reset clears
// - Width flag one for wide structures
// - Width flag derived, read only, reset zero
// - Narrow mode takes high address byte from init
// - Upper address lines always driven
// - I/O width follows word I/O select only
// - Style field steers structure width and order
// - Style gated writes, reset to 00h
// - Other fields independent of style
// - Style codes 00h, 02h, 03h defined
module sss_top (
  // Clock, reset and enable
  input  wire        MCLK,
  input  wire        ARST_N,
  input  wire        CE,
  // Register port
  input  wire [7:0]  ADDR,
  input  wire [31:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output wire [31:0] RDATA,
  // Controller run state, same clock
  input  wire        STOP,
  input  wire        SUSPEND_REQ,
  // Descriptor engine master address and parity events
  input  wire [31:0] DMA_ADDR,
  input  wire        DMA_DATA_PERR,
  input  wire        TGT_DATA_PERR,
  input  wire        ADDR_PERR,
  // Master address towards the bus
  output wire [31:0] MASTER_ADDR,
  output wire [7:0]  MASTER_ADDR_HI_OE,
  // Descriptor marking and error report
  output wire        BPE_MARK,
  output wire [31:0] BPE_MASK,
  output wire        PERR_REPORT,
  // Decoded configuration
  output wire        WIDE_STRUCT,
  output wire        BURST_DESC,
  output wire        STYLE_RESERVED,
  output wire [7:0]  STRUCT_STYLE,
  output wire        WORD_IO
);

  // Synchronised reset
  wire rst_n;

  // Stored configuration
  reg  [7:0]  style_r;         // Style field
  reg  [7:0]  style_nxt;       // Style next value
  reg         apar_r;          // Advanced parity mark enable
  reg         apar_nxt;        // Parity enable next value
  reg         wide_r;          // Wide structure flag
  reg         burst_r;         // Burst descriptors
  reg         res_r;           // Reserved style loaded
  reg  [7:0]  init_hi_r;       // High init address byte
  reg  [7:0]  init_hi_nxt;     // Init byte next value
  reg         word_io_r;       // Word I/O select
  reg         word_io_nxt;     // Word I/O next value

  // Output and read flops
  reg  [31:0] rdata_r;         // Read data, one cycle late
  reg  [31:0] rdata_nxt;       // Read data next value
  reg  [31:0] maddr_r;         // Master address out
  reg  [7:0]  hi_oe_r;         // High address drive enable
  reg         bpe_r;           // Buffer parity mark pulse
  reg         perr_r;          // Parity error report pulse

  // Decoder results on the next style
  wire        dec_wide;        // Wide for next style
  wire        dec_burst;       // Burst for next style
  wire        dec_res;         // Reserved next style

  // Access qualifiers
  wire        gate_open;       // Writes allowed
  wire        hit_style;       // Either style name hit

  // Register offset compare
  function is_ofs;
    input [7:0] a;
    input [7:0] o;
    begin
      is_ofs = (a == o);
    end
  endfunction

  // Reset release
  sss_rst_sync u_rst (
    .clk    (MCLK),
    .arst_n (ARST_N),
    .rst_n  (rst_n)
  );

  // Style attributes from the value about to be stored
  sss_style_dec u_dec (
    .style    (style_nxt),
    .wide     (dec_wide),
    .burst    (dec_burst),
    .reserved (dec_res)
  );

  // Gated fields open in stop or suspend only
  assign gate_open = STOP | SUSPEND_REQ;

  // Alias and mirror decode onto one storage
  assign hit_style = is_ofs(ADDR, `SSS_OFS_STYLE) |
                     is_ofs(ADDR, `SSS_OFS_MIRROR);

  // Next values of the style register fields
  always @* begin
    style_nxt = style_r;
    apar_nxt  = apar_r;
    // Permitted write only, others silently dropped
    if (WR && hit_style && gate_open) begin
      style_nxt = WDATA[`SSS_STYLE_MSB:`SSS_STYLE_LSB];
      apar_nxt  = WDATA[`SSS_APAR_BIT];
    end
  end

  // Next values of the neighbouring configuration
  always @* begin
    init_hi_nxt = init_hi_r;
    word_io_nxt = word_io_r;
    // Init byte, always writable, style independent
    if (WR && is_ofs(ADDR, `SSS_OFS_INIT_HI)) begin
      init_hi_nxt = WDATA[`SSS_INIT_HI_MSB:`SSS_INIT_HI_LSB];
    end
    // Bus mode word I/O select
    if (WR && is_ofs(ADDR, `SSS_OFS_BUS_MODE)) begin
      word_io_nxt = WDATA[`SSS_WORD_IO_BIT];
    end
  end

  // Configuration storage, cleared only by hardware reset
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      style_r   <= `SSS_RST_STYLE;
      apar_r    <= `SSS_RST_APAR;
      wide_r    <= 1'b0;
      burst_r   <= 1'b0;
      res_r     <= 1'b0;
      init_hi_r <= `SSS_RST_INIT_HI;
      word_io_r <= `SSS_RST_WORD_IO;
    end else if (CE) begin
      style_r   <= style_nxt;
      apar_r    <= apar_nxt;
      // Flag tracks the style on the same edge
      wide_r    <= dec_wide;
      burst_r   <= dec_burst;
      res_r     <= dec_res;
      init_hi_r <= init_hi_nxt;
      word_io_r <= word_io_nxt;
    end
  end

  // Read multiplexer
  always @* begin
    rdata_nxt = 32'h00000000;
    if (hit_style) begin
      // Same image through either name
      rdata_nxt[`SSS_STYLE_MSB:`SSS_STYLE_LSB] = style_r;
      rdata_nxt[`SSS_WIDE_BIT] = wide_r;
      rdata_nxt[`SSS_APAR_BIT] = apar_r;
    end else if (is_ofs(ADDR, `SSS_OFS_INIT_HI)) begin
      rdata_nxt[`SSS_INIT_HI_MSB:`SSS_INIT_HI_LSB] = init_hi_r;
    end else if (is_ofs(ADDR, `SSS_OFS_BUS_MODE)) begin
      rdata_nxt[`SSS_WORD_IO_BIT] = word_io_r;
    end else if (is_ofs(ADDR, `SSS_OFS_STATUS)) begin
      // Run state and style attributes
      rdata_nxt[0] = STOP;
      rdata_nxt[1] = SUSPEND_REQ;
      rdata_nxt[2] = burst_r;
      rdata_nxt[3] = res_r;
    end else begin
      // Unmapped offsets read zero
      rdata_nxt = 32'h00000000;
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
    end else if (CE) begin
      if (RD) begin
        rdata_r <= rdata_nxt;
      end else begin
        rdata_r <= 32'h00000000;
      end
    end
  end

  // Master address, high byte from init in narrow mode
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      maddr_r <= 32'h00000000;
      hi_oe_r <= 8'hFF;
    end else if (CE) begin
      if (wide_r) begin
        maddr_r <= DMA_ADDR;
      end else begin
        maddr_r <= {init_hi_r, DMA_ADDR[23:0]};
      end
      // Drive is independent of the width flag
      hi_oe_r <= 8'hFF;
    end
  end

  // Parity marking and reporting
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      bpe_r  <= 1'b0;
      perr_r <= 1'b0;
    end else if (CE) begin
      // Mark only master data errors when enabled
      bpe_r  <= apar_r & DMA_DATA_PERR;
      // Report path never looks at the enable
      perr_r <= ADDR_PERR | TGT_DATA_PERR | DMA_DATA_PERR;
    end
  end

  // Register port output
  assign RDATA             = rdata_r;

  // Bus address outputs
  assign MASTER_ADDR       = maddr_r;
  assign MASTER_ADDR_HI_OE = hi_oe_r;

  // Descriptor mark: pulse plus fixed bit mask
  assign BPE_MARK          = bpe_r;
  assign BPE_MASK          = {{8{1'b0}}, bpe_r, {`SSS_BPE_BIT{1'b0}}};
  assign PERR_REPORT       = perr_r;

  // Decoded configuration outputs
  assign WIDE_STRUCT       = wide_r;
  assign BURST_DESC        = burst_r;
  assign STYLE_RESERVED    = res_r;
  assign STRUCT_STYLE      = style_r;
  assign WORD_IO           = word_io_r;

endmodule
